// file: core/boot_mode_selector.sv
// Notes on behaviour
// - pin-select word is valid only when bits 31:24 hold 0x5A
// - no valid zone word: sample default pins, index default table
// - both zones valid: zone two wins over zone one
// - pin fields at 7:0, 15:8, 23:16 name the GPIO number to sample
// - field value 0xFF disables that pin; nothing sampled for it
// - pin lsb is index bit 0, pin msb is index bit 2
// - each pin keeps its bit weight whatever the others do
// - enabled pin count sets reachable entries: 1, 2, 4 or 8
// - configured pins use the user table instead of the default table
// - table is low and high words, entry n at bits 8n+7:8n
// - low nibble of chosen entry is the boot mode number
// - high nibble of chosen entry carries option bits
// - unsupported mode: wait with debugger, flash standalone
// - modes 0 parallel to 8 CAN-FD as numbered
// - every reset runs the lookup and selects the boot option
// - after decoding, the select pins are released for reuse
// - two-pin variant: msb unused, both pins may share one GPIO
// - defaults: GPIO24 mid, GPIO32 lsb, 00 parallel to 11 flash
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/100ps
module boot_mode_selector #(
   parameter int GPIO_COUNT = 256
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic [7:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   input  wire logic [3:0]            byteenable,
   output logic      [31:0]           readdata,
   output logic                       waitrequest,
   input  wire logic [GPIO_COUNT-1:0] gpio_in,
   input  wire logic                  debugger_attached,
   output logic      [3:0]            boot_mode,
   output logic      [3:0]            boot_options,
   output logic                       boot_done,
   output logic                       select_pins_held
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic cfg_valid(input logic [31:0] cfg);
      cfg_valid = (cfg[boot_mode_pkg::KEY_LSB +: 8] == boot_mode_pkg::CONFIG_VALID_KEY);
   endfunction

   function automatic logic sample_pin(input logic [GPIO_COUNT-1:0] gpio,
                                       input logic [7:0]            num);
      sample_pin = 1'b0;
      if (num != boot_mode_pkg::PIN_DISABLED && 32'(num) < GPIO_COUNT) begin
         sample_pin = gpio[num];
      end
   endfunction

   function automatic logic [7:0] entry_of(input logic [63:0] table_v,
                                           input logic [2:0]  idx);
      entry_of = table_v[{idx, 3'b000} +: 8];
   endfunction

   function automatic logic [31:0] merge_be(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  be);
      merge_be = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge_be[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0]                 zone1_pin_q;
   logic [31:0]                 zone1_low_q;
   logic [31:0]                 zone1_high_q;
   logic [31:0]                 zone2_pin_q;
   logic [31:0]                 zone2_low_q;
   logic [31:0]                 zone2_high_q;
   logic [31:0]                 ctrl_q;
   logic [31:0]                 readdata_q;
   logic                        waitrequest_q;
   boot_mode_pkg::state_t       state_q;
   logic [31:0]                 cfg_q;
   logic [63:0]                 table_q;
   boot_mode_pkg::boot_result_t res_q;
   logic [3:0]                  mode_q;
   logic [3:0]                  options_q;
   logic [2:0]                  index_q;
   logic [1:0]                  source_q;
   logic                        unsup_q;
   logic                        done_q;
   logic                        held_q;
   logic                        finished_q;
   logic                        wr_take;
   logic                        req_new;
   logic                        rerun_req;
   logic [31:0]                 status_w;
   logic [7:0]                  entry_w;

   assign wr_take   = write && !waitrequest_q;
   assign req_new   = (read || write) && waitrequest_q;
   assign rerun_req = wr_take && address == boot_mode_pkg::ADDR_CTRL
                      && byteenable[0] && writedata[boot_mode_pkg::CTRL_RERUN];
   assign entry_w   = entry_of(table_q, res_q.index);
   assign res_q     = '{mode: mode_q, options: options_q, index: index_q,
                        source: source_q, unsupported: unsup_q};

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[boot_mode_pkg::ST_MODE_LSB +: 4] = res_q.mode;
      status_w[boot_mode_pkg::ST_OPT_LSB +: 4]  = res_q.options;
      status_w[boot_mode_pkg::ST_IDX_LSB +: 3]  = res_q.index;
      status_w[boot_mode_pkg::ST_SRC_LSB +: 2]  = res_q.source;
      status_w[boot_mode_pkg::ST_UNSUP]         = res_q.unsupported;
      status_w[boot_mode_pkg::ST_DONE]          = finished_q;
      status_w[boot_mode_pkg::ST_HELD]          = held_q;
   end

   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, then answer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         waitrequest_q <= 1'b1;
      end else if (req_new) begin
         waitrequest_q <= 1'b0;
      end else begin
         waitrequest_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         readdata_q <= 32'h0000_0000;
      end else if (read && waitrequest_q) begin
         unique case (address)
            boot_mode_pkg::ADDR_ONE_PIN:   readdata_q <= zone1_pin_q;
            boot_mode_pkg::ADDR_ONE_LOW:   readdata_q <= zone1_low_q;
            boot_mode_pkg::ADDR_ONE_HIGH:  readdata_q <= zone1_high_q;
            boot_mode_pkg::ADDR_TWO_PIN:   readdata_q <= zone2_pin_q;
            boot_mode_pkg::ADDR_TWO_LOW:   readdata_q <= zone2_low_q;
            boot_mode_pkg::ADDR_TWO_HIGH:  readdata_q <= zone2_high_q;
            boot_mode_pkg::ADDR_CTRL:      readdata_q <= ctrl_q;
            boot_mode_pkg::ADDR_STATUS:    readdata_q <= status_w;
            default:                       readdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // configuration words
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zone1_pin_q  <= boot_mode_pkg::OTP_RESET;
         zone1_low_q  <= boot_mode_pkg::OTP_RESET;
         zone1_high_q <= boot_mode_pkg::OTP_RESET;
         zone2_pin_q  <= boot_mode_pkg::OTP_RESET;
         zone2_low_q  <= boot_mode_pkg::OTP_RESET;
         zone2_high_q <= boot_mode_pkg::OTP_RESET;
      end else if (wr_take) begin
         if (address == boot_mode_pkg::ADDR_ONE_PIN) begin
            zone1_pin_q <= merge_be(zone1_pin_q, writedata, byteenable);
         end
         if (address == boot_mode_pkg::ADDR_ONE_LOW) begin
            zone1_low_q <= merge_be(zone1_low_q, writedata, byteenable);
         end
         if (address == boot_mode_pkg::ADDR_ONE_HIGH) begin
            zone1_high_q <= merge_be(zone1_high_q, writedata, byteenable);
         end
         if (address == boot_mode_pkg::ADDR_TWO_PIN) begin
            zone2_pin_q <= merge_be(zone2_pin_q, writedata, byteenable);
         end
         if (address == boot_mode_pkg::ADDR_TWO_LOW) begin
            zone2_low_q <= merge_be(zone2_low_q, writedata, byteenable);
         end
         if (address == boot_mode_pkg::ADDR_TWO_HIGH) begin
            zone2_high_q <= merge_be(zone2_high_q, writedata, byteenable);
         end
      end
   end

   // rerun bit self-clears; only the two-pin bit is stored
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= boot_mode_pkg::CTRL_RESET;
      end else if (wr_take && address == boot_mode_pkg::ADDR_CTRL && byteenable[0]) begin
         ctrl_q[boot_mode_pkg::CTRL_TWO_PIN] <= writedata[boot_mode_pkg::CTRL_TWO_PIN];
      end
   end

   // ----------------------------------------------------------------
   // lookup sequence
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= boot_mode_pkg::ST_PICK;
      end else begin
         unique case (state_q)
            boot_mode_pkg::ST_IDLE:   state_q <= rerun_req ? boot_mode_pkg::ST_PICK
                                                          : boot_mode_pkg::ST_IDLE;
            boot_mode_pkg::ST_PICK:   state_q <= boot_mode_pkg::ST_SAMPLE;
            boot_mode_pkg::ST_SAMPLE: state_q <= boot_mode_pkg::ST_DECODE;
            boot_mode_pkg::ST_DECODE: state_q <= boot_mode_pkg::ST_FINISH;
            boot_mode_pkg::ST_FINISH: state_q <= boot_mode_pkg::ST_IDLE;
         endcase
      end
   end

   // zone choice and table choice
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_q    <= boot_mode_pkg::DEFAULT_PIN_CFG;
         table_q  <= boot_mode_pkg::DEFAULT_TABLE;
         source_q <= boot_mode_pkg::SRC_DEFAULT;
      end else if (state_q == boot_mode_pkg::ST_PICK) begin
         if (cfg_valid(zone2_pin_q)) begin
            cfg_q    <= zone2_pin_q;
            table_q  <= {zone2_high_q, zone2_low_q};
            source_q <= boot_mode_pkg::SRC_ZONE_TWO;
         end else if (cfg_valid(zone1_pin_q)) begin
            cfg_q    <= zone1_pin_q;
            table_q  <= {zone1_high_q, zone1_low_q};
            source_q <= boot_mode_pkg::SRC_ZONE_ONE;
         end else begin
            cfg_q    <= boot_mode_pkg::DEFAULT_PIN_CFG;
            table_q  <= boot_mode_pkg::DEFAULT_TABLE;
            source_q <= boot_mode_pkg::SRC_DEFAULT;
         end
         if (ctrl_q[boot_mode_pkg::CTRL_TWO_PIN]) begin
            cfg_q[boot_mode_pkg::PIN_MSB_POS +: 8] <= boot_mode_pkg::PIN_DISABLED;
         end
      end
   end

   // pin sampling into a weighted index
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         index_q <= 3'b000;
      end else if (state_q == boot_mode_pkg::ST_SAMPLE) begin
         index_q <= {sample_pin(gpio_in, cfg_q[boot_mode_pkg::PIN_MSB_POS +: 8]),
                     sample_pin(gpio_in, cfg_q[boot_mode_pkg::PIN_MID_POS +: 8]),
                     sample_pin(gpio_in, cfg_q[boot_mode_pkg::PIN_LSB_POS +: 8])};
      end
   end

   // entry decode
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_q    <= boot_mode_pkg::MODE_PARALLEL;
         options_q <= 4'h0;
         unsup_q   <= 1'b0;
      end else if (state_q == boot_mode_pkg::ST_DECODE) begin
         options_q <= entry_w[7:4];
         if (entry_w[3:0] > boot_mode_pkg::MODE_CAN_FD) begin
            unsup_q <= 1'b1;
            mode_q  <= debugger_attached ? boot_mode_pkg::MODE_WAIT
                                         : boot_mode_pkg::MODE_FLASH;
         end else begin
            unsup_q <= 1'b0;
            mode_q  <= entry_w[3:0];
         end
      end
   end

   // done pulse and pin release
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done_q     <= 1'b0;
         held_q     <= 1'b1;
         finished_q <= 1'b0;
      end else begin
         done_q <= (state_q == boot_mode_pkg::ST_FINISH);
         if (state_q == boot_mode_pkg::ST_FINISH) begin
            held_q     <= 1'b0;
            finished_q <= 1'b1;
         end else if (state_q == boot_mode_pkg::ST_PICK) begin
            held_q     <= 1'b1;
            finished_q <= 1'b0;
         end
      end
   end

   assign readdata         = readdata_q;
   assign waitrequest      = waitrequest_q;
   assign boot_mode        = res_q.mode;
   assign boot_options     = res_q.options;
   assign boot_done        = done_q;
   assign select_pins_held = held_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_zone_two_wins:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_PICK && cfg_valid(zone2_pin_q)
      |=> res_q.source == boot_mode_pkg::SRC_ZONE_TWO)
      else $error("zone two config not preferred");

   a_default_fallback:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_PICK && !cfg_valid(zone1_pin_q) && !cfg_valid(zone2_pin_q)
      |=> res_q.source == boot_mode_pkg::SRC_DEFAULT
          && table_q == boot_mode_pkg::DEFAULT_TABLE)
      else $error("default path not taken");

   a_key_required:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_PICK ##1 res_q.source == boot_mode_pkg::SRC_ZONE_ONE
      |-> cfg_valid($past(zone1_pin_q)))
      else $error("zone one used without key");

   a_table_zone:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_PICK && !cfg_valid(zone2_pin_q) && cfg_valid(zone1_pin_q)
      |=> table_q == {$past(zone1_high_q), $past(zone1_low_q)})
      else $error("zone one table not selected");

   a_two_pin_msb:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_PICK && ctrl_q[boot_mode_pkg::CTRL_TWO_PIN]
      |=> cfg_q[boot_mode_pkg::PIN_MSB_POS +: 8] == boot_mode_pkg::PIN_DISABLED)
      else $error("two-pin mode kept msb pin");

   a_disabled_zero:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_SAMPLE
      && cfg_q[boot_mode_pkg::PIN_MSB_POS +: 8] == boot_mode_pkg::PIN_DISABLED
      |=> !res_q.index[2])
      else $error("disabled pin drove index");

   a_index_weight:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_SAMPLE
      |=> res_q.index[0] == $past(sample_pin(gpio_in, cfg_q[7:0])))
      else $error("lsb pin not at index bit 0");

   a_mode_nibble:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_DECODE && entry_w[3:0] <= boot_mode_pkg::MODE_CAN_FD
      |=> res_q.mode == $past(entry_w[3:0]) && res_q.options == $past(entry_w[7:4]))
      else $error("mode or options not from entry");

   a_unsupported_fallback:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_DECODE && entry_w[3:0] > boot_mode_pkg::MODE_CAN_FD
      && !debugger_attached
      |=> res_q.mode == boot_mode_pkg::MODE_FLASH)
      else $error("standalone unsupported mode not flash");

   a_wait_debug:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_DECODE && entry_w[3:0] > boot_mode_pkg::MODE_CAN_FD
      && debugger_attached
      |=> res_q.mode == boot_mode_pkg::MODE_WAIT && res_q.unsupported)
      else $error("unsupported mode with debugger not wait");

   a_pins_release:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_PICK |-> ##4 done_q ##0 !held_q)
      else $error("pins not released with done");

   a_pins_held:
   assert property (@(posedge ref_clk) disable iff (rst)
      state_q == boot_mode_pkg::ST_SAMPLE |-> held_q)
      else $error("select pins released before sampling");

   a_done_pulse:
   assert property (@(posedge ref_clk) disable iff (rst)
      done_q |=> !done_q)
      else $error("done longer than one cycle");

endmodule

// file: shared/boot_mode_pkg.sv
package boot_mode_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ONE_PIN  = 8'h00;
   localparam logic [7:0] ADDR_ONE_LOW  = 8'h04;
   localparam logic [7:0] ADDR_ONE_HIGH = 8'h08;
   localparam logic [7:0] ADDR_TWO_PIN  = 8'h0C;
   localparam logic [7:0] ADDR_TWO_LOW  = 8'h10;
   localparam logic [7:0] ADDR_TWO_HIGH = 8'h14;
   localparam logic [7:0] ADDR_CTRL     = 8'h18;
   localparam logic [7:0] ADDR_STATUS   = 8'h1C;

   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   localparam int KEY_LSB      = 24;
   localparam int PIN_LSB_POS  = 0;
   localparam int PIN_MID_POS  = 8;
   localparam int PIN_MSB_POS  = 16;
   localparam int CTRL_RERUN   = 0;
   localparam int CTRL_TWO_PIN = 1;
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_OPT_LSB   = 4;
   localparam int ST_IDX_LSB   = 8;
   localparam int ST_SRC_LSB   = 11;
   localparam int ST_UNSUP     = 13;
   localparam int ST_DONE      = 16;
   localparam int ST_HELD      = 17;

   // ----------------------------------------------------------------
   // values
   // ----------------------------------------------------------------
   localparam logic [7:0]  CONFIG_VALID_KEY = 8'h5A;
   localparam logic [7:0]  PIN_DISABLED     = 8'hFF;
   localparam logic [31:0] OTP_RESET        = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
   // default pins: lsb GPIO32, mid GPIO24, msb unused
   localparam logic [31:0] DEFAULT_PIN_CFG  = 32'h00FF_1820;
   // default table: 0 parallel, 1 serial, 2 CAN, 3 flash
   localparam logic [63:0] DEFAULT_TABLE    = 64'h0000_0000_0302_0100;

   localparam logic [3:0] MODE_PARALLEL = 4'h0;
   localparam logic [3:0] MODE_SERIAL   = 4'h1;
   localparam logic [3:0] MODE_CAN      = 4'h2;
   localparam logic [3:0] MODE_FLASH    = 4'h3;
   localparam logic [3:0] MODE_WAIT     = 4'h4;
   localparam logic [3:0] MODE_RAM      = 4'h5;
   localparam logic [3:0] MODE_SPI      = 4'h6;
   localparam logic [3:0] MODE_I2C      = 4'h7;
   localparam logic [3:0] MODE_CAN_FD   = 4'h8;

   localparam logic [1:0] SRC_DEFAULT  = 2'h0;
   localparam logic [1:0] SRC_ZONE_ONE = 2'h1;
   localparam logic [1:0] SRC_ZONE_TWO = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PICK,
      ST_SAMPLE,
      ST_DECODE,
      ST_FINISH
   } state_t;

   typedef struct packed {
      logic [3:0] mode;
      logic [3:0] options;
      logic [2:0] index;
      logic [1:0] source;
      logic       unsupported;
   } boot_result_t;

endpackage

// file: tb/boot_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// external boot pins
// ----------------------------------------------------------------
module boot_pin_model (
   input  wire logic         ref_clk,
   input  wire logic         select_pins_held,
   input  wire logic [255:0] pin_levels,
   output logic      [255:0] gpio_in
);
   logic toggle_q = 1'b0;

   always_ff @(posedge ref_clk) begin
      toggle_q <= ~toggle_q;
   end

   // released pins carry application traffic: the boot levels, inverted on alternate cycles
   always_comb begin
      if (select_pins_held) begin
         gpio_in = pin_levels;
      end else begin
         gpio_in = ~pin_levels ^ {256{toggle_q}};
      end
   end
endmodule

// file: tb/tb_boot_mode_selector.sv
`timescale 1ns/100ps
module tb_boot_mode_selector;
   logic         ref_clk;
   logic         rst;
   logic [7:0]   address;
   logic         read;
   logic         write;
   logic [31:0]  writedata;
   logic [3:0]   byteenable;
   logic [31:0]  readdata;
   logic         waitrequest;
   logic [255:0] gpio_in;
   logic [255:0] pins;
   logic         debugger_attached;
   logic [3:0]   boot_mode;
   logic [3:0]   boot_options;
   logic         boot_done;
   logic         select_pins_held;
   int           fail_count = 0;
   int           checks = 0;
   int           cycles = 0;
   logic [31:0]  q;
   localparam logic [63:0] TBL_A = 64'h2716_F5E4_D3C2_B1A0;
   localparam logic [63:0] TBL_B = 64'h8796_7564_5342_3120;
   localparam logic [63:0] TBL_C = 64'h0000_0000_006F_5938;

   boot_mode_selector i_boot_mode_selector (
      .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .gpio_in(gpio_in), .debugger_attached(debugger_attached),
      .boot_mode(boot_mode), .boot_options(boot_options), .boot_done(boot_done),
      .select_pins_held(select_pins_held));

   boot_pin_model i_boot_pin_model (
      .ref_clk(ref_clk), .select_pins_held(select_pins_held), .pin_levels(pins),
      .gpio_in(gpio_in));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_boot(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // bus and lookup helpers
   // ----------------------------------------------------------------
   task automatic bus_op(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      byteenable <= 4'hF;
      write <= wr_en;
      read <= ~wr_en;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_op(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      bus_op(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (boot_done !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      check_boot(boot_done, 4'h1);
   endtask

   function automatic logic [2:0] idx_of(input logic [31:0] cfg, input logic [255:0] lv);
      logic [7:0] f;
      idx_of = 3'h0;
      for (int b = 0; b < 3; b++) begin
         f = cfg[8*b +: 8];
         idx_of[b] = (f != 8'hFF) && lv[f];
      end
   endfunction

   task automatic run_check(input logic [31:0] cfg, input logic [63:0] tbl,
                            input logic [255:0] lv, input logic dbg, input logic two,
                            input logic [1:0] src);
      logic [2:0] idx;
      logic [7:0] ent;
      logic [3:0] m;
      idx = idx_of(cfg, lv) & {~two, 2'b11};
      ent = tbl[8*idx +: 8];
      m = (ent[3:0] > 4'h8) ? (dbg ? 4'h4 : 4'h3) : ent[3:0];
      pins <= lv;
      debugger_attached <= dbg;
      wr(boot_mode_pkg::ADDR_CTRL, {30'h0000_0000, two, 1'b1});
      wait_done();
      check_boot(boot_mode, m);
      check_boot(boot_options, ent[7:4]);
      check_boot(select_pins_held, 4'h0);
      @(posedge ref_clk);
      check_boot(boot_done, 4'h0);
      repeat (3) @(posedge ref_clk);
      check_boot(boot_mode, m);
      rd(boot_mode_pkg::ADDR_STATUS);
      check_bus(32'(q[12:8]), 32'({src, idx}));
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_defaults();
      for (int v = 0; v < 4; v++) begin
         pins <= '0;
         pins[32] <= v[0];
         pins[24] <= v[1];
         rst <= 1'b1;
         repeat (2) @(posedge ref_clk);
         rst <= 1'b0;
         wait_done();
         check_boot(boot_mode, v[3:0]);
         check_boot(boot_options, 4'h0);
      end
   endtask

   task automatic s_registers();
      rd(boot_mode_pkg::ADDR_ONE_PIN);
      check_bus(q, boot_mode_pkg::OTP_RESET);
      wr(boot_mode_pkg::ADDR_ONE_LOW, TBL_A[31:0]);
      wr(boot_mode_pkg::ADDR_ONE_HIGH, TBL_A[63:32]);
      rd(boot_mode_pkg::ADDR_ONE_HIGH);
      check_bus(q, TBL_A[63:32]);
      rd(8'h20);
      check_bus(q, 32'h0000_0000);
   endtask

   task automatic s_zone_one();
      wr(boot_mode_pkg::ADDR_ONE_PIN, 32'h5AC8_4005);
      for (int i = 0; i < 8; i++) begin
         run_check(32'h5AC8_4005, TBL_A, (256'(i[0]) << 5) | (256'(i[1]) << 64)
                   | (256'(i[2]) << 200), 1'b0, 1'b0, 2'h1);
      end
      wr(boot_mode_pkg::ADDR_ONE_PIN, 32'h5AC8_FFFF);
      run_check(32'h5AC8_FFFF, TBL_A, ~256'h0, 1'b0, 1'b0, 2'h1);
      wr(boot_mode_pkg::ADDR_ONE_PIN, 32'h5AFF_FFFF);
      run_check(32'h5AFF_FFFF, TBL_A, ~256'h0, 1'b0, 1'b0, 2'h1);
      wr(boot_mode_pkg::ADDR_ONE_PIN, 32'h5A00_0707);
      run_check(32'h5A00_0707, TBL_A, 256'h81, 1'b0, 1'b1, 2'h1);
   endtask

   task automatic s_modes();
      wr(boot_mode_pkg::ADDR_ONE_PIN, 32'h5AFF_FF05);
      wr(boot_mode_pkg::ADDR_ONE_LOW, TBL_C[31:0]);
      wr(boot_mode_pkg::ADDR_ONE_HIGH, TBL_C[63:32]);
      run_check(32'h5AFF_FF05, TBL_C, ~256'h20, 1'b0, 1'b0, 2'h1);
      run_check(32'h5AFF_FF05, TBL_C, 256'h20, 1'b1, 1'b0, 2'h1);
      run_check(32'h5AFF_FF05, TBL_C, 256'h20, 1'b0, 1'b0, 2'h1);
   endtask

   task automatic s_zone_two();
      wr(boot_mode_pkg::ADDR_TWO_LOW, TBL_B[31:0]);
      wr(boot_mode_pkg::ADDR_TWO_HIGH, TBL_B[63:32]);
      wr(boot_mode_pkg::ADDR_TWO_PIN, 32'h5A0A_0B0C);
      run_check(32'h5A0A_0B0C, TBL_B, 256'h1C00, 1'b0, 1'b0, 2'h2);
      wr(boot_mode_pkg::ADDR_TWO_PIN, 32'h5B0A_0B0C);
      run_check(32'h5AFF_FF05, TBL_C, 256'h1C00, 1'b0, 1'b0, 2'h1);
   endtask

   initial begin
      rst = 1'b1;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
      pins = '0;
      debugger_attached = 1'b0;
      s_defaults();
      s_registers();
      s_zone_one();
      s_modes();
      s_zone_two();
      summarize();
   end
endmodule
